// ### design/pfsw_ctrl.sv
// flash self-write controller: table access, unlock, row erase/program
`timescale 1ns/100ps
// How it works
// - rows of 32 words, erase whole row
// - low table ops reach bits 15..0
// - high table ops reach bits 23..16
// - address is page byte joined to EA
// - 32 latches, each picked by EA bits 5..1
// - table write finishes in two cycles
// - each row needs its own program cycle
// - low address captures EA 15..0, picks row
// - upper address captures the page byte, bits 23..16
// - direct address writes replace captured address
// - write-only key, 0x55 then 0xAA
// - control selects operation and holds start
// - bit 15 starts, hardware clears at end
// - operation lasts 2 ms, cpu stalled
module pfsw_ctrl
    import pfsw_pkg::*;
#(
    parameter int OP_CYCLES = OP_TIME_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [15:0] sfrAddr,
    input wire logic [15:0] sfrWrData,
    output logic [15:0] sfrRdData,
    input wire logic tblValid,
    input wire logic tblWrite,
    input wire logic tblHigh,
    input wire logic tblByte,
    input wire logic [7:0] tablePageReg,
    input wire logic [15:0] tblEa,
    input wire logic [15:0] tblWrData,
    output logic [15:0] tblRdData,
    output logic tblDone,
    output logic cpuStall,
    output logic [ADDR_W-1:0] arrayAddr,
    input wire logic [WORD_W-1:0] arrayRdData,
    output logic arrayErase,
    output logic arrayWrEn,
    output logic [WORD_W-1:0] arrayWrData
);
    // ****************************************************************
    // state
    // ****************************************************************
    pfsw_key_t key_q, key_d;
    pfsw_op_t op_q, op_d;
    logic start_q, start_d;
    logic write_enable_bit_q, write_enable_bit_d;
    logic err_q, err_d;
    logic twri_q, twri_d;
    logic [6:0] opSel_q, opSel_d;
    logic [15:0] addrLow_q, addrLow_d;
    logic [7:0] addrUp_q, addrUp_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic [LATCH_IDX_W:0] wcnt_q, wcnt_d;
    logic [15:0] sfrRdData_q, sfrRdData_d;
    logic [1:0] tblPh_q, tblPh_d;
    logic tblWr_q, tblWr_d, tblHi_q, tblHi_d, tblBy_q, tblBy_d;
    logic tblOdd_q, tblOdd_d;
    logic [15:0] tblRdData_q, tblRdData_d;
    logic tblDone_q, tblDone_d;
    logic [ADDR_W-1:0] arrayAddr_q, arrayAddr_d;
    logic arrayErase_q, arrayErase_d;
    logic arrayWrEn_q, arrayWrEn_d;
    logic [WORD_W-1:0] arrayWrData_q, arrayWrData_d;
    logic latWrEn_q, latWrEn_d;
    logic [2:0] latLane_q, latLane_d;
    logic [LATCH_IDX_W-1:0] latIdx_q, latIdx_d;
    logic [WORD_W-1:0] latData_q, latData_d;

    pfsw_latch_if lat ();

    pfsw_latch_mem u_latch (
        .clk (clk),
        .lat (lat)
    );

    assign lat.write_enable_bit = latWrEn_q;
    assign lat.wrLane = latLane_q;
    assign lat.wrIdx = latIdx_q;
    assign lat.wrData = latData_q;
    assign lat.rdIdx = wcnt_q[LATCH_IDX_W-1:0];

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [ADDR_W-1:0] rowBase(input logic [7:0] up,
                                                  input logic [15:0] lo);
        logic [ADDR_W-1:0] a;
        a = {up, lo};
        a[ROW_ADDR_LSB-1:0] = '0;
        return a;
    endfunction

    function automatic logic [15:0] ctlWord(input logic st, input logic en,
                                            input logic er, input logic tw,
                                            input logic [6:0] op);
        logic [15:0] w;
        w = 16'h0000;
        w[CTL_START_BIT] = st;
        w[CTL_WRITE_ENABLE_BIT_BIT] = en;
        w[CTL_ERR_BIT] = er;
        w[CTL_TWRI_BIT] = tw;
        w[CTL_OP_MSB:0] = op;
        return w;
    endfunction

    logic ctlWr, lowWr, upWr, keyWr, tblTake;
    assign ctlWr = sfrWrEn && (sfrAddr == OFS_CONTROL);
    assign lowWr = sfrWrEn && (sfrAddr == OFS_ADDR_LOW);
    assign upWr = sfrWrEn && (sfrAddr == OFS_ADDR_UPPER);
    assign keyWr = sfrWrEn && (sfrAddr == OFS_UNLOCK_KEY);
    // table ops wait while the array is busy; the stall holds the cpu
    assign tblTake = tblValid && (op_q == OP_IDLE) && (tblPh_q == 2'h0);

    // ****************************************************************
    // registers, unlock and sequencer
    // ****************************************************************
    always_comb begin
        key_d = key_q;
        op_d = op_q;
        start_d = start_q;
        write_enable_bit_d = write_enable_bit_q;
        err_d = err_q;
        twri_d = twri_q;
        opSel_d = opSel_q;
        addrLow_d = addrLow_q;
        addrUp_d = addrUp_q;
        timer_d = timer_q;
        wcnt_d = wcnt_q;
        arrayErase_d = 1'b0;
        arrayWrEn_d = 1'b0;
        arrayWrData_d = arrayWrData_q;
        arrayAddr_d = arrayAddr_q;
        sfrRdData_d = sfrRdData_q;

        // key tracking: only the exact pair arms a start
        if (sfrWrEn) begin
            if (keyWr && sfrWrData[7:0] == KEY_FIRST) begin
                key_d = KEY_GOT1;
            end else if (keyWr && sfrWrData[7:0] == KEY_SECOND &&
                         key_q == KEY_GOT1) begin
                key_d = KEY_ARMED;
            end else begin
                key_d = KEY_IDLE;
            end
        end

        // captured address from the last table instruction
        if (tblTake) begin
            addrLow_d = tblEa;
            addrUp_d = tablePageReg;
        end
        if (lowWr && op_q == OP_IDLE) begin
            addrLow_d = sfrWrData;
        end
        if (upWr && op_q == OP_IDLE) begin
            addrUp_d = sfrWrData[7:0];
        end

        if (ctlWr && op_q == OP_IDLE) begin
            write_enable_bit_d = sfrWrData[CTL_WRITE_ENABLE_BIT_BIT];
            err_d = sfrWrData[CTL_ERR_BIT];
            twri_d = sfrWrData[CTL_TWRI_BIT];
            opSel_d = sfrWrData[CTL_OP_MSB:0];
            // start needs the armed key (checked before this write) and
            // write enable; either missing leaves start clear
            if (sfrWrData[CTL_START_BIT] && key_q == KEY_ARMED &&
                sfrWrData[CTL_WRITE_ENABLE_BIT_BIT]) begin
                if (sfrWrData[CTL_OP_MSB:0] == OP_ERASE_ROW) begin
                    start_d = 1'b1;
                    op_d = OP_ERASE;
                end else if (sfrWrData[CTL_OP_MSB:0] == OP_PROG_ROW) begin
                    start_d = 1'b1;
                    op_d = OP_PROG;
                end else begin
                    err_d = 1'b1;
                end
                timer_d = '0;
                wcnt_d = '0;
            end
        end

        case (op_q)
            OP_IDLE: begin
            end
            OP_ERASE: begin
                // one pulse clears the whole selected row
                arrayAddr_d = rowBase(addrUp_q, addrLow_q);
                arrayErase_d = 1'b1;
                timer_d = timer_q + 1'b1;
                op_d = OP_WAIT;
            end
            OP_PROG: begin
                // latch read is registered: write lags index by one cycle
                timer_d = timer_q + 1'b1;
                wcnt_d = wcnt_q + 1'b1;
                if (wcnt_q != '0) begin
                    arrayWrEn_d = 1'b1;
                    arrayWrData_d = lat.rdData;
                    arrayAddr_d = rowBase(addrUp_q, addrLow_q) +
                        {{(ADDR_W-LATCH_IDX_W-1){1'b0}},
                         (wcnt_q[LATCH_IDX_W-1:0] - 1'b1), 1'b0};
                end
                if (wcnt_q == ROW_WORDS[LATCH_IDX_W:0]) begin
                    op_d = OP_WAIT;
                end
            end
            OP_WAIT: begin
                timer_d = timer_q + 1'b1;
                if (timer_q >= OP_CYCLES[TIMER_W-1:0] - 1'b1) begin
                    start_d = 1'b0;
                    op_d = OP_IDLE;
                end
            end
            default: begin
                op_d = OP_IDLE;
            end
        endcase

        // reads: key is write-only and reads back zero
        if (sfrRdEn) begin
            case (sfrAddr)
                OFS_CONTROL: sfrRdData_d =
                    ctlWord(start_q, write_enable_bit_q, err_q, twri_q, opSel_q);
                OFS_ADDR_LOW: sfrRdData_d = addrLow_q;
                OFS_ADDR_UPPER: sfrRdData_d = {8'h00, addrUp_q};
                default: sfrRdData_d = 16'h0000;
            endcase
        end
    end

    // ****************************************************************
    // table read and write path
    // ****************************************************************
    always_comb begin
        tblPh_d = tblPh_q;
        tblWr_d = tblWr_q;
        tblHi_d = tblHi_q;
        tblBy_d = tblBy_q;
        tblOdd_d = tblOdd_q;
        tblRdData_d = tblRdData_q;
        tblDone_d = 1'b0;
        latWrEn_d = 1'b0;
        latLane_d = latLane_q;
        latIdx_d = latIdx_q;
        latData_d = latData_q;
        if (tblTake) begin
            tblPh_d = 2'h1;
            tblWr_d = tblWrite;
            tblHi_d = tblHigh;
            tblBy_d = tblByte;
            tblOdd_d = tblEa[0];
            // word index inside the row: EA bits 5..1 pick one of latches 0..31
            latIdx_d = tblEa[LATCH_IDX_W:1];
            latWrEn_d = tblWrite;
            latData_d = {tblWrData[7:0], tblWrData};
            if (!tblHigh) begin
                if (!tblByte) begin
                    latLane_d = 3'h3;
                end else if (tblEa[0]) begin
                    latLane_d = 3'h2;
                    latData_d = {8'h00, tblWrData[7:0], 8'h00};
                end else begin
                    latLane_d = 3'h1;
                end
            end else begin
                // odd high byte is the phantom byte: write ignored
                latLane_d = (tblByte && tblEa[0]) ? 3'h0 : 3'h4;
            end
        end else if (tblPh_q != 2'h0) begin
            tblPh_d = tblPh_q + 1'b1;
            if (tblPh_q == TBL_DONE_CNT - 1'b1) begin
                tblPh_d = 2'h0;
                tblDone_d = 1'b1;
                if (!tblWr_q) begin
                    if (!tblHi_q) begin
                        tblRdData_d = arrayRdData[15:0];
                        if (tblBy_q) begin
                            tblRdData_d = {8'h00, tblOdd_q ?
                                arrayRdData[15:8] : arrayRdData[7:0]};
                        end
                    end else begin
                        tblRdData_d = (tblBy_q && tblOdd_q) ? 16'h0000 :
                            {8'h00, arrayRdData[23:16]};
                    end
                end
            end
        end
    end

    // array read address shares the port with program/erase addresses
    logic [ADDR_W-1:0] arrayAddrMux;
    always_comb begin
        arrayAddrMux = arrayAddr_d;
        if (tblTake) begin
            arrayAddrMux = {tablePageReg, tblEa[15:1], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            key_q <= KEY_IDLE;
            op_q <= OP_IDLE;
            start_q <= CONTROL_RST[CTL_START_BIT];
            write_enable_bit_q <= CONTROL_RST[CTL_WRITE_ENABLE_BIT_BIT];
            err_q <= CONTROL_RST[CTL_ERR_BIT];
            twri_q <= CONTROL_RST[CTL_TWRI_BIT];
            opSel_q <= CONTROL_RST[CTL_OP_MSB:0];
            addrLow_q <= ADDR_LOW_RST;
            addrUp_q <= ADDR_UPPER_RST;
            timer_q <= '0;
            wcnt_q <= '0;
            sfrRdData_q <= 16'h0000;
            tblPh_q <= 2'h0;
            tblWr_q <= 1'b0;
            tblHi_q <= 1'b0;
            tblBy_q <= 1'b0;
            tblOdd_q <= 1'b0;
            tblRdData_q <= 16'h0000;
            tblDone_q <= 1'b0;
            arrayAddr_q <= '0;
            arrayErase_q <= 1'b0;
            arrayWrEn_q <= 1'b0;
            arrayWrData_q <= '0;
            latWrEn_q <= 1'b0;
            latLane_q <= 3'h0;
            latIdx_q <= '0;
            latData_q <= '0;
        end else begin
            key_q <= key_d;
            op_q <= op_d;
            start_q <= start_d;
            write_enable_bit_q <= write_enable_bit_d;
            err_q <= err_d;
            twri_q <= twri_d;
            opSel_q <= opSel_d;
            addrLow_q <= addrLow_d;
            addrUp_q <= addrUp_d;
            timer_q <= timer_d;
            wcnt_q <= wcnt_d;
            sfrRdData_q <= sfrRdData_d;
            tblPh_q <= tblPh_d;
            tblWr_q <= tblWr_d;
            tblHi_q <= tblHi_d;
            tblBy_q <= tblBy_d;
            tblOdd_q <= tblOdd_d;
            tblRdData_q <= tblRdData_d;
            tblDone_q <= tblDone_d;
            arrayAddr_q <= arrayAddrMux;
            arrayErase_q <= arrayErase_d;
            arrayWrEn_q <= arrayWrEn_d;
            arrayWrData_q <= arrayWrData_d;
            latWrEn_q <= latWrEn_d;
            latLane_q <= latLane_d;
            latIdx_q <= latIdx_d;
            latData_q <= latData_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign sfrRdData = sfrRdData_q;
    assign tblRdData = tblRdData_q;
    assign tblDone = tblDone_q;
    assign cpuStall = start_q;
    assign arrayAddr = arrayAddr_q;
    assign arrayErase = arrayErase_q;
    assign arrayWrEn = arrayWrEn_q;
    assign arrayWrData = arrayWrData_q;
endmodule

// ### include/pfsw_pkg.sv
// shared constants and types for the flash self-write controller
package pfsw_pkg;
    // ****************************************************************
    // array geometry
    // ****************************************************************
    localparam int ROW_WORDS = 32;
    localparam int ROW_BYTES = 96;
    localparam int PANEL_ROWS = 128;
    localparam int LATCH_IDX_W = 5;
    localparam int WORD_W = 24;
    localparam int ADDR_W = 24;
    // row base: program addresses step by two per word
    localparam int ROW_ADDR_LSB = 6;
    // ****************************************************************
    // register offsets and fields
    // ****************************************************************
    localparam logic [15:0] OFS_CONTROL = 16'h0760;
    localparam logic [15:0] OFS_ADDR_LOW = 16'h0762;
    localparam logic [15:0] OFS_ADDR_UPPER = 16'h0764;
    localparam logic [15:0] OFS_UNLOCK_KEY = 16'h0766;
    localparam int CTL_START_BIT = 15;
    localparam int CTL_WRITE_ENABLE_BIT_BIT = 14;
    localparam int CTL_ERR_BIT = 13;
    localparam int CTL_TWRI_BIT = 8;
    localparam int CTL_OP_MSB = 6;
    localparam logic [6:0] OP_ERASE_ROW = 7'h41;
    localparam logic [6:0] OP_PROG_ROW = 7'h01;
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [15:0] ADDR_LOW_RST = 16'h0000;
    localparam logic [7:0] ADDR_UPPER_RST = 8'h00;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OP_TIME_US = 2000;
    localparam int OP_TIME_CYC =
        (OP_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int TIMER_W = 20;
    localparam logic [1:0] TBL_DONE_CNT = 2'h2;

    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} pfsw_key_t;
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROG, OP_WAIT}
        pfsw_op_t;
endpackage

// ### include/pfsw_latch_if.sv
// carrier between the controller and its write latch store
`timescale 1ns/100ps
interface pfsw_latch_if;
    import pfsw_pkg::*;
    logic write_enable_bit;
    logic [2:0] wrLane;
    logic [LATCH_IDX_W-1:0] wrIdx;
    logic [WORD_W-1:0] wrData;
    logic [LATCH_IDX_W-1:0] rdIdx;
    logic [WORD_W-1:0] rdData;
    modport ctrl (output write_enable_bit, wrLane, wrIdx, wrData, rdIdx, input rdData);
    modport store (input write_enable_bit, wrLane, wrIdx, wrData, rdIdx, output rdData);
endinterface

// ### design/pfsw_latch_mem.sv
// one row of write latches, byte-lane writes, registered read
`timescale 1ns/100ps
module pfsw_latch_mem
    import pfsw_pkg::*;
(
    input wire logic clk,
    pfsw_latch_if.store lat
);
    logic [WORD_W-1:0] mem [ROW_WORDS];
    logic [WORD_W-1:0] rdData_q;

    // no reset on the array: latch contents are undefined until loaded
    always_ff @(posedge clk) begin
        if (lat.write_enable_bit) begin
            for (int b = 0; b < 3; b++) begin
                if (lat.wrLane[b]) begin
                    mem[lat.wrIdx][b*8 +: 8] <= lat.wrData[b*8 +: 8];
                end
            end
        end
        rdData_q <= mem[lat.rdIdx];
    end

    assign lat.rdData = rdData_q;
endmodule

// ### sim/pfsw_ctrl_asserts.sv
// concurrent checks on the flash self-write controller ports
`timescale 1ns/100ps
module pfsw_ctrl_asserts
    import pfsw_pkg::*;
#(
    parameter int OP_CYCLES = OP_TIME_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sfrWrEn,
    input wire logic [15:0] sfrAddr,
    input wire logic [15:0] sfrWrData,
    input wire logic tblValid,
    input wire logic tblDone,
    input wire logic cpuStall,
    input wire logic [ADDR_W-1:0] arrayAddr,
    input wire logic arrayErase,
    input wire logic arrayWrEn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****************************************************************
    // helper state
    // ****************************************************************
    logic [1:0] keyQ, keyD;
    logic [TIMER_W-1:0] stallCntQ, stallCntD;
    logic isKey, ctlStart;
    assign isKey = sfrWrEn && (sfrAddr == OFS_UNLOCK_KEY);
    assign ctlStart = sfrWrEn && (sfrAddr == OFS_CONTROL) && sfrWrData[15];
    always_comb begin
        keyD = keyQ;
        stallCntD = cpuStall ? stallCntQ + 1'b1 : '0;
        if (sfrWrEn) begin
            if (isKey && sfrWrData[7:0] == KEY_FIRST)
                keyD = 2'h1;
            else if (isKey && sfrWrData[7:0] == KEY_SECOND && keyQ == 2'h1)
                keyD = 2'h2;
            else
                keyD = 2'h0;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            keyQ <= 2'h0;
            stallCntQ <= '0;
        end else begin
            keyQ <= keyD;
            stallCntQ <= stallCntD;
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    sequence s_tblReq;
        $rose(tblValid) && !cpuStall;
    endsequence
    sequence s_opStart;
        $rose(cpuStall);
    endsequence
    property p_tbl_lat;
        s_tblReq |-> ##2 tblDone;
    endproperty
    a_tbl_lat: assert property (p_tbl_lat)
        else $error("table op done not two cycles after request");
    property p_done_pulse;
        tblDone |=> !tblDone;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("table done longer than one cycle");
    property p_op_act;
        s_opStart |-> ##[1:2] (arrayErase || arrayWrEn);
    endproperty
    a_op_act: assert property (p_op_act)
        else $error("started operation touched no array");
    property p_row_base;
        arrayErase |-> arrayAddr[ROW_ADDR_LSB-1:0] == '0;
    endproperty
    a_row_base: assert property (p_row_base)
        else $error("erase address not a row base");
    property p_erase_once;
        arrayErase |=> !arrayErase [*8];
    endproperty
    a_erase_once: assert property (p_erase_once)
        else $error("row erased more than once");
    property p_wr_in_op;
        arrayWrEn |-> cpuStall;
    endproperty
    a_wr_in_op: assert property (p_wr_in_op)
        else $error("array written outside a program cycle");
    property p_stall_hold;
        s_opStart |-> cpuStall [*8];
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("stall dropped early");
    property p_stall_len;
        $fell(cpuStall) |-> stallCntQ == TIMER_W'(OP_CYCLES);
    endproperty
    a_stall_len: assert property (p_stall_len)
        else $error("stall length wrong");
    property p_key;
        ctlStart && keyQ != 2'h2 && !cpuStall |=> !cpuStall;
    endproperty
    a_key: assert property (p_key)
        else $error("operation started without unlock");
endmodule
bind pfsw_ctrl pfsw_ctrl_asserts #(.OP_CYCLES(OP_CYCLES)) chk (
    .clk(clk), .sys_rst(sys_rst), .sfrWrEn(sfrWrEn), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .tblValid(tblValid), .tblDone(tblDone),
    .cpuStall(cpuStall), .arrayAddr(arrayAddr), .arrayErase(arrayErase),
    .arrayWrEn(arrayWrEn));

// ### sim/pfsw_array_model.sv
// behavioural flash array behind the controller
`timescale 1ns/100ps
module pfsw_array_model
    import pfsw_pkg::*;
(
    input wire logic clk,
    input wire logic [ADDR_W-1:0] arrayAddr,
    input wire logic arrayErase,
    input wire logic arrayWrEn,
    input wire logic [WORD_W-1:0] arrayWrData,
    output logic [WORD_W-1:0] arrayRdData
);
    // only 256 words kept: upper address bits alias, enough for eight rows
    logic [WORD_W-1:0] mem [0:255];
    // combinational read: the controller takes the word one cycle after
    // it moves the address, so a registered read would come too late
    assign arrayRdData = mem[arrayAddr[8:1]];
    initial begin
        foreach (mem[i]) mem[i] = 24'h000000;
    end
    always @(posedge clk) begin
        if (arrayErase) begin
            for (int i = 0; i < ROW_WORDS; i++)
                mem[{arrayAddr[8:6], i[4:0]}] <= 24'hFFFFFF;
        end
        if (arrayWrEn)
            mem[arrayAddr[8:1]] <= arrayWrData;
    end
endmodule

// ### sim/test_program_flash_self_write.sv
// self-checking bench for the flash self-write controller
`timescale 1ns/100ps
module test_program_flash_self_write
    import pfsw_pkg::*;
;
    localparam int OPC = 200;
    logic clk, sysRst, sfrWrEn, sfrRdEn, tblValid, tblWrite, tblHigh;
    logic tblByte, tblDone, cpuStall, arrayErase, arrayWrEn, ran;
    logic [15:0] sfrAddr, sfrWrData, sfrRdData, tblEa, tblWrData, tblRdData;
    logic [15:0] rd;
    logic [7:0] pageReg;
    logic [23:0] arrayAddr, arrayRdData, arrayWrData;
    int nFail, checkCount;
    pfsw_ctrl #(.OP_CYCLES(OPC)) dut (.clk(clk), .sys_rst(sysRst),
        .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .tblValid(tblValid),
        .tblWrite(tblWrite), .tblHigh(tblHigh), .tblByte(tblByte),
        .tablePageReg(pageReg), .tblEa(tblEa), .tblWrData(tblWrData),
        .tblRdData(tblRdData), .tblDone(tblDone), .cpuStall(cpuStall),
        .arrayAddr(arrayAddr), .arrayRdData(arrayRdData),
        .arrayErase(arrayErase), .arrayWrEn(arrayWrEn),
        .arrayWrData(arrayWrData));
    pfsw_array_model farEnd (.clk(clk), .arrayAddr(arrayAddr),
        .arrayErase(arrayErase), .arrayWrEn(arrayWrEn),
        .arrayWrData(arrayWrData), .arrayRdData(arrayRdData));
    always #2.5 clk = ~clk;
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [23:0] exp,
        input logic [23:0] got);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic sfr_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        sfrWrEn = 1'b1;
        sfrAddr = a;
        sfrWrData = d;
        @(posedge clk);
        #1;
        sfrWrEn = 1'b0;
    endtask
    task automatic sfr_rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        sfrRdEn = 1'b1;
        sfrAddr = a;
        @(posedge clk);
        #1;
        sfrRdEn = 1'b0;
        @(posedge clk);
        #1;
        d = sfrRdData;
    endtask
    task automatic tbl_op(input logic wr, input logic hi, input logic [7:0] pg,
        input logic [15:0] ea, input logic [15:0] wd, output logic [15:0] d);
        int n;
        @(posedge clk);
        #1;
        {tblValid, tblWrite, tblHigh, pageReg, tblEa, tblWrData} =
            {1'b1, wr, hi, pg, ea, wd};
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tblDone !== 1'b1 && n < 8);
        tblValid = 1'b0;
        chk("table latency", 24'(n), 24'h000002);
        d = tblRdData;
    endtask
    task automatic keys;
        sfr_wr(OFS_UNLOCK_KEY, 16'h0055);
        sfr_wr(OFS_UNLOCK_KEY, 16'h00AA);
    endtask
    task automatic wait_op(output logic r);
        int n;
        r = 1'b0;
        repeat (3) begin
            @(posedge clk);
            #1;
            if (cpuStall === 1'b1) r = 1'b1;
        end
        n = 0;
        while (cpuStall !== 1'b0 && n < OPC + 20) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        logic [15:0] a [5] = '{OFS_CONTROL, OFS_ADDR_LOW, OFS_ADDR_UPPER,
            OFS_UNLOCK_KEY, 16'h0768};
        logic [15:0] e [5] = '{CONTROL_RST, ADDR_LOW_RST,
            {8'h00, ADDR_UPPER_RST}, 16'h0000, 16'h0000};
        sfr_wr(OFS_UNLOCK_KEY, 16'h0055);
        for (int i = 0; i < 5; i++) begin
            sfr_rd(a[i], rd);
            chk("reset read", e[i], rd);
        end
    endtask
    task automatic t_erase;
        sfr_wr(OFS_ADDR_UPPER, 16'h0000);
        sfr_wr(OFS_ADDR_LOW, 16'h0048);
        keys();
        sfr_wr(OFS_CONTROL, 16'hC041);
        wait_op(ran);
        chk("erase ran", 1, ran);
        sfr_rd(OFS_CONTROL, rd);
        chk("start cleared", 16'h4041, rd);
        chk("erased first", 24'hFFFFFF, farEnd.mem[32]);
        chk("erased last", 24'hFFFFFF, farEnd.mem[63]);
        chk("next row kept", 0, farEnd.mem[64]);
    endtask
    task automatic t_program;
        // aligned row, filled from word 0 upward
        for (int i = 0; i < 32; i++) begin
            tbl_op(1, 0, 8'h00, 16'h0080 + 16'(2 * i), 16'hA500 + 16'(i), rd);
            tbl_op(1, 1, 8'h00, 16'h0080 + 16'(2 * i), 16'h5A30 + 16'(i), rd);
        end
        keys();
        sfr_wr(OFS_CONTROL, 16'hC001);
        wait_op(ran);
        chk("program ran", 1, ran);
        for (int i = 0; i < 32; i++)
            chk("programmed word", {8'h30 + 8'(i), 16'hA500 + 16'(i)},
                farEnd.mem[64 + i]);
    endtask
    task automatic t_read;
        tbl_op(0, 0, 8'h12, 16'h0084, 16'h0000, rd);
        chk("low read", 16'hA502, rd);
        chk("table address", 24'h120084, arrayAddr);
        tbl_op(0, 1, 8'h12, 16'h0084, 16'h0000, rd);
        chk("high read", 16'h0032, rd);
        sfr_rd(OFS_ADDR_LOW, rd);
        chk("captured low", 16'h0084, rd);
        sfr_rd(OFS_ADDR_UPPER, rd);
        chk("captured upper", 16'h0012, rd);
        tblByte = 1'b1;
        tbl_op(0, 0, 8'h12, 16'h0085, 16'h0000, rd);
        chk("odd byte read", 16'h00A5, rd);
        tbl_op(0, 1, 8'h12, 16'h0085, 16'h0000, rd);
        chk("phantom byte read", 16'h0000, rd);
        tblByte = 1'b0;
    endtask
    task automatic t_refuse;
        sfr_wr(OFS_UNLOCK_KEY, 16'h0055);
        sfr_wr(OFS_ADDR_LOW, 16'h0080);
        sfr_wr(OFS_UNLOCK_KEY, 16'h00AA);
        sfr_wr(OFS_CONTROL, 16'hC041);
        wait_op(ran);
        chk("broken key", 0, ran);
        keys();
        sfr_wr(OFS_CONTROL, 16'h8041);
        wait_op(ran);
        chk("no enable", 0, ran);
        chk("row kept", 24'h30A500, farEnd.mem[64]);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        nFail++;
        final_report();
    end
    initial begin
        {clk, sfrWrEn, sfrRdEn, tblValid, tblWrite, tblHigh, tblByte} = '0;
        {sfrAddr, sfrWrData, tblEa, tblWrData, pageReg} = '0;
        nFail = 0;
        checkCount = 0;
        sysRst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        sysRst = 1'b0;
        t_reset();
        t_erase();
        t_program();
        t_read();
        t_refuse();
        final_report();
    end
endmodule
